// >>> dv/sbsc_assertions.sv
// Port checker for the burst SRAM cycle control
`timescale 1ns/1ps
`default_nettype none
module sbsc_assertions
(
	input wire logic				clk_i,
	input wire logic				rst_i,
	input wire logic				ce_i,
	input wire logic				pipelined_chip_select_n_i,
	input wire logic				expansion_select_high_i,
	input wire logic				expansion_select_low_n_i,
	input wire logic				processor_address_strobe_n_i,
	input wire logic				controller_address_strobe_n_i,
	input wire logic				burst_advance_n_i,
	input wire logic				global_write_n_i,
	input wire logic				byte_write_gate_n_i,
	input wire logic [sbsc_pkg::LANES-1:0]		byte_lane_select_n_i,
	input wire logic				output_enable_n_i,
	input wire logic				sleep_request_i,
	input wire logic [sbsc_pkg::DATA_W-1:0]	data_o,
	input wire logic [sbsc_pkg::LANES-1:0]		parity_o,
	input wire logic				data_oe_o,
	input wire logic				parity_oe_o
);
	logic	[2:0]	awake_ff;
	logic		sel, proc, ctrl, wr_n, live;
	assign sel = !pipelined_chip_select_n_i & expansion_select_high_i & !expansion_select_low_n_i;
	assign proc = !processor_address_strobe_n_i & !pipelined_chip_select_n_i;
	assign ctrl = !proc & !controller_address_strobe_n_i;
	assign wr_n = global_write_n_i & (byte_write_gate_n_i | &byte_lane_select_n_i);
	assign live = ce_i & (awake_ff >= 3'h5);
	// Margin over the sleep synchroniser latency
	always_ff @(posedge clk_i or posedge rst_i)
		if (rst_i)
			awake_ff <= 3'h0;
		else
			awake_ff <= sleep_request_i ? 3'h0 : awake_ff + {2'h0, awake_ff != 3'h7};
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	oe_gate_a: assert property (output_enable_n_i |-> !data_oe_o) else $error("drive while disabled");
	lane_oe_a: assert property (data_oe_o == parity_oe_o) else $error("parity drive differs");
	proc_read_a: assert property (live & sel & proc |=> output_enable_n_i | data_oe_o) else $error("no read");
	ctrl_read_a: assert property (live & sel & ctrl & wr_n |=> output_enable_n_i | data_oe_o) else $error("no read");
	begin_write_a: assert property (live & sel & ctrl & !wr_n |=> !data_oe_o) else $error("drive in write");
	burst_write_a: assert property (live & !proc & controller_address_strobe_n_i & !wr_n |=> !data_oe_o)
		else $error("drive in burst write");
	deselect_a: assert property (live & (proc | ctrl) & !sel |=> !data_oe_o) else $error("drive when off");
	sleep_off_a: assert property (sleep_request_i [*5] |-> !data_oe_o) else $error("drive in sleep");
	suspend_hold_a: assert property (live & data_oe_o & !proc & controller_address_strobe_n_i
		& burst_advance_n_i & wr_n |=> $stable({parity_o, data_o})) else $error("suspend data moved");
endmodule : sbsc_assertions
`default_nettype wire

// >>> dv/sbsc_master.sv
// Bus master side: output enable steering
`timescale 1ns/1ps
`default_nettype none
module sbsc_master
(
	input wire logic	write_plan_i,
	output logic		output_enable_n_o
);
	assign output_enable_n_o = write_plan_i;
endmodule : sbsc_master
`default_nettype wire

// >>> dv/sbsc_top_test.sv
// Self-checking bench for the burst SRAM cycle control
`timescale 1ns/1ps
`default_nettype none
module sbsc_top_test;
	localparam logic [5:0] S_CTL = 6'h15, S_NXT = 6'h16, S_SUS = 6'h17, S_PRC = 6'h13, S_OFF = 6'h35;
	logic clk_i = 0, rst_i = 1, ce_i = 1, burst_order_i = 0, sleep_request_i = 0, plan = 0;
	logic pipelined_chip_select_n_i = 1, expansion_select_high_i = 1, expansion_select_low_n_i = 0;
	logic processor_address_strobe_n_i = 1, controller_address_strobe_n_i = 1, burst_advance_n_i = 1;
	logic global_write_n_i = 1, byte_write_gate_n_i = 1, output_enable_n_i, data_oe_o, parity_oe_o;
	logic [3:0] byte_lane_select_n_i = 4'hf, parity_i = 4'h0, parity_o;
	logic [31:0] data_i = 32'h0, data_o, x = 32'h4e, b;
	logic [17:0] addr_i = 18'h0, a, base;
	logic [35:0] q[$], pend, md[int];
	logic [1:0] stp;
	logic act = 0, pv = 0, slp = 0;
	int errors = 0, checks = 0;
	sbsc_top dut (.*);
	sbsc_master master (.write_plan_i(plan), .output_enable_n_o(output_enable_n_i));
	always #4 clk_i = !clk_i;
	function automatic logic [31:0] rnd();
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction : rnd
	task automatic bad(input string m);
		$display("unexpected at %0t: %s", $time, m);
		errors++;
	endtask : bad
	// st = {chip select, both expansion selects, both strobes, advance}; wr 1 byte, 2 global
	task automatic cyc(input logic [5:0] st, input logic [1:0] wr, input logic [17:0] a);
		logic [31:0] d;
		logic [3:0] ln;
		logic sel, pr, ct, w;
		logic [17:0] ea;
		d = rnd();
		ln = wr == 2 ? 4'hf : (wr == 1 ? ~d[7:4] : 4'h0);
		sel = !st[5] & st[4] & !st[3];
		pr = !st[2] & !st[5];
		ct = !pr & !st[1];
		w = |ln && !pr && !slp && (ct ? sel : act);
		@(posedge clk_i);
		{pipelined_chip_select_n_i, expansion_select_high_i, expansion_select_low_n_i} <= st[5:3];
		{processor_address_strobe_n_i, controller_address_strobe_n_i, burst_advance_n_i} <= st[2:0];
		global_write_n_i <= wr != 2;
		byte_write_gate_n_i <= wr != 1;
		byte_lane_select_n_i <= d[7:4];
		addr_i <= a;
		data_i <= d;
		parity_i <= d[11:8];
		plan <= w;
		if (pv && !w)
			q.push_back(pend);
		pv = 0;
		if (!slp && (pr | ct))
		begin
			act = sel;
			base = a;
			stp = 2'h0;
		end
		else if (!slp && act && !st[0])
			stp++;
		ea = {base[17:2], burst_order_i ? base[1:0] ^ stp : base[1:0] + stp};
		if (!slp && act && w)
			for (int i = 0; i < 4; i++)
				if (ln[i])
					{md[ea][32+i], md[ea][8*i+:8]} = {d[8+i], d[8*i+:8]};
		if (!slp && act && !w)
		begin
			pend = md[ea];
			pv = 1;
		end
	endtask : cyc
	always @(negedge clk_i)
		if (data_oe_o === 1'b1)
		begin
			checks++;
			if (q.size() == 0) bad("drive without a read");
			else if ({parity_o, data_o} !== q.pop_front()) bad("read data");
		end
		else if (data_oe_o !== 1'b0) bad("drive enable unknown");
	task automatic finish_test();
		if (q.size() != 0) bad("read results missing");
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : finish_test
	initial
	begin
		#20000;
		bad("timeout");
		finish_test();
	end
	initial
	begin
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		for (int o = 0; o < 2; o++)
		begin
			burst_order_i <= o[0];
			b = rnd();
			a = b[17:0];
			cyc(S_CTL, 2, a);
			repeat (3) cyc(S_NXT, 2, a);
			// Read from another start in the group so the order shows
			cyc(S_PRC, 0, a ^ 18'h1);
			repeat (3) cyc(S_NXT, 0, a);
			cyc(S_OFF, 0, a);
			$display("test burst order %0d done", o);
		end
		for (int k = 0; k < 4; k++)
		begin
			cyc(S_PRC, 2, a);
			cyc(S_SUS, 1, a);
			cyc(S_CTL, 0, a);
			cyc(S_SUS, 0, a);
			cyc(S_OFF, 0, a);
		end
		$display("test byte lanes done");
		cyc(6'h03, 0, a);
		cyc(S_NXT, 0, a);
		cyc(S_OFF, 0, a);
		$display("test deselect done");
		@(posedge clk_i);
		ce_i <= 0;
		// Frozen clock enable must ignore the pins just as sleep does
		slp = 1;
		cyc(S_PRC, 0, a);
		cyc(S_CTL, 2, a);
		cyc(S_OFF, 0, a);
		ce_i <= 1;
		slp = 0;
		cyc(S_PRC, 0, a);
		cyc(S_OFF, 0, a);
		$display("test clock enable done");
		sleep_request_i <= 1;
		slp = 1;
		repeat (6) cyc(S_OFF, 0, a);
		cyc(S_PRC, 0, a);
		cyc(S_OFF, 0, a);
		sleep_request_i <= 0;
		repeat (6) cyc(S_OFF, 0, a);
		slp = 0;
		cyc(S_PRC, 0, a);
		cyc(S_OFF, 0, a);
		$display("test sleep done");
		repeat (2) @(posedge clk_i);
		finish_test();
	end
endmodule : sbsc_top_test
bind sbsc_top sbsc_assertions chk (.*);
`default_nettype wire

// >>> logic/sbsc_mem.sv
// Byte-lane core array with registered read data
`timescale 1ns/1ps
`default_nettype none
module sbsc_mem
(
	input  wire logic                                         clk_i,
	input  wire logic                                         rst_i,
	input  wire logic                                         ce_i,
	input  wire logic [sbsc_pkg::ADDR_W-1:0]                  addr_i,
	input  wire logic                                         rd_en_i,
	input  wire logic [sbsc_pkg::LANES-1:0]                   lane_we_i,
	input  wire logic [sbsc_pkg::LANES*sbsc_pkg::LANE_W-1:0]  wdata_i,
	output logic      [sbsc_pkg::LANES*sbsc_pkg::LANE_W-1:0]  rdata_o
);
	localparam int DEPTH = 1 << sbsc_pkg::ADDR_W;

	genvar g;
	generate
		for (g = 0; g < sbsc_pkg::LANES; g++)
		begin : g_lane
			logic [sbsc_pkg::LANE_W-1:0] mem_ff [DEPTH];

			always_ff @(posedge clk_i)
			begin
				if (ce_i && lane_we_i[g])
					mem_ff[addr_i] <= wdata_i[g*sbsc_pkg::LANE_W +: sbsc_pkg::LANE_W];
			end

			// Read register gives flow-through timing: data follow the access edge
			always_ff @(posedge clk_i or posedge rst_i)
			begin
				if (rst_i)
					rdata_o[g*sbsc_pkg::LANE_W +: sbsc_pkg::LANE_W] <= '0;
				else if (ce_i && rd_en_i)
					rdata_o[g*sbsc_pkg::LANE_W +: sbsc_pkg::LANE_W] <= mem_ff[addr_i];
			end
		end
	endgenerate
endmodule : sbsc_mem
`default_nettype wire

// >>> logic/sbsc_pkg.sv
// Constants and types shared by the burst SRAM cycle control
package sbsc_pkg;
	localparam int ADDR_W = 18;
	localparam int LANES  = 4;
	localparam int BYTE_W = 8;
	localparam int LANE_W = 9;
	localparam int DATA_W = 32;
	localparam int CNT_W  = 2;
	localparam int HI_W   = ADDR_W - CNT_W;

	localparam logic [CNT_W-1:0] CNT_ZERO = 2'h0;
	localparam logic [CNT_W-1:0] CNT_ONE  = 2'h1;

	typedef enum logic [2:0]
	{
		SBSC_ST_IDLE  = 3'h1,
		SBSC_ST_BURST = 3'h2,
		SBSC_ST_SLEEP = 3'h4
	} sbsc_state_type;
endpackage : sbsc_pkg

// >>> logic/sbsc_top.sv
// Cycle control of a flow-through burst SRAM with byte-lane writes
`timescale 1ns/1ps
`default_nettype none
module sbsc_top
(
	input  wire logic                                   clk_i,
	input  wire logic                                   rst_i,
	input  wire logic                                   ce_i,
	input  wire logic [sbsc_pkg::ADDR_W-1:0]            addr_i,
	input  wire logic                                   pipelined_chip_select_n_i,
	input  wire logic                                   expansion_select_high_i,
	input  wire logic                                   expansion_select_low_n_i,
	input  wire logic                                   processor_address_strobe_n_i,
	input  wire logic                                   controller_address_strobe_n_i,
	input  wire logic                                   burst_advance_n_i,
	input  wire logic                                   global_write_n_i,
	input  wire logic                                   byte_write_gate_n_i,
	input  wire logic [sbsc_pkg::LANES-1:0]             byte_lane_select_n_i,
	input  wire logic                                   output_enable_n_i,
	input  wire logic                                   burst_order_i,
	input  wire logic                                   sleep_request_i,
	input  wire logic [sbsc_pkg::DATA_W-1:0]            data_i,
	input  wire logic [sbsc_pkg::LANES-1:0]             parity_i,
	output logic      [sbsc_pkg::DATA_W-1:0]            data_o,
	output logic      [sbsc_pkg::LANES-1:0]             parity_o,
	output logic                                        data_oe_o,
	output logic                                        parity_oe_o
);
	sbsc_pkg::sbsc_state_type state_ff;
	sbsc_pkg::sbsc_state_type nxt_state;

	logic                                         sleep_meta_ff;
	logic                                         sleep_sync_ff;
	logic [sbsc_pkg::HI_W-1:0]                    hi_ff;
	logic [sbsc_pkg::CNT_W-1:0]                   start_ff;
	logic [sbsc_pkg::CNT_W-1:0]                   step_ff;
	logic [sbsc_pkg::CNT_W-1:0]                   nxt_step;
	logic [sbsc_pkg::CNT_W-1:0]                   low_addr;
	logic                                         read_valid_ff;

	logic                                         sel;
	logic                                         proc_start;
	logic                                         ctrl_start;
	logic                                         write_n;
	logic [sbsc_pkg::LANES-1:0]                   lane_wr;
	logic                                         live;
	logic                                         begin_rd;
	logic                                         begin_wr;
	logic                                         cont;
	logic                                         rd_en;
	logic [sbsc_pkg::LANES-1:0]                   lane_we;
	logic [sbsc_pkg::ADDR_W-1:0]                  acc_addr;
	logic [sbsc_pkg::LANES*sbsc_pkg::LANE_W-1:0]  wdata;
	logic [sbsc_pkg::LANES*sbsc_pkg::LANE_W-1:0]  rdata;

	// Sleep pin is asynchronous; the two stages also give the two-cycle entry
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sleep_meta_ff <= 1'b0;
			sleep_sync_ff <= 1'b0;
		end
		else if (ce_i)
		begin
			sleep_meta_ff <= sleep_request_i;
			sleep_sync_ff <= sleep_meta_ff;
		end
	end

	assign live = (state_ff != sbsc_pkg::SBSC_ST_SLEEP) && !sleep_sync_ff;

	assign sel = !pipelined_chip_select_n_i && expansion_select_high_i && !expansion_select_low_n_i;

	// Processor strobe counts only with the pipelined select low
	assign proc_start = !processor_address_strobe_n_i && !pipelined_chip_select_n_i;
	assign ctrl_start = !proc_start && !controller_address_strobe_n_i;

	assign write_n = global_write_n_i && (byte_write_gate_n_i || (&byte_lane_select_n_i));

	assign lane_wr = global_write_n_i ? (~byte_lane_select_n_i & {sbsc_pkg::LANES{!byte_write_gate_n_i}})
	                                  : {sbsc_pkg::LANES{1'b1}};

	// processor start reads, write inputs ignored
	assign begin_rd = live && sel && (proc_start || (ctrl_start && write_n));

	assign begin_wr = live && sel && ctrl_start && !write_n;

	// strobe without full select begins nothing
	// writes follow a processor start, never in it
	assign cont = live && !proc_start && controller_address_strobe_n_i
	              && (state_ff == sbsc_pkg::SBSC_ST_BURST);

	assign nxt_step = (cont && !burst_advance_n_i) ? step_ff + sbsc_pkg::CNT_ONE : step_ff;

	assign low_addr = burst_order_i ? (start_ff ^ nxt_step) : (start_ff + nxt_step);

	assign acc_addr = (begin_rd || begin_wr) ? addr_i : {hi_ff, low_addr};

	assign rd_en = begin_rd || (cont && write_n);

	// burst writes take pin data regardless of output enable
	assign lane_we = (begin_wr || (cont && !write_n)) ? lane_wr : '0;

	genvar g;
	generate
		for (g = 0; g < sbsc_pkg::LANES; g++)
		begin : g_pack
			assign wdata[g*sbsc_pkg::LANE_W +: sbsc_pkg::LANE_W] =
				{parity_i[g], data_i[g*sbsc_pkg::BYTE_W +: sbsc_pkg::BYTE_W]};
			assign parity_o[g] = rdata[g*sbsc_pkg::LANE_W + sbsc_pkg::BYTE_W];
			assign data_o[g*sbsc_pkg::BYTE_W +: sbsc_pkg::BYTE_W] =
				rdata[g*sbsc_pkg::LANE_W +: sbsc_pkg::BYTE_W];
		end
	endgenerate

	// read register loads at the access edge
	sbsc_mem u_mem
	(
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.ce_i      (ce_i),
		.addr_i    (acc_addr),
		.rd_en_i   (rd_en),
		.lane_we_i (lane_we),
		.wdata_i   (wdata),
		.rdata_o   (rdata)
	);

	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			sbsc_pkg::SBSC_ST_IDLE:
			begin
				if (sleep_sync_ff)
					nxt_state = sbsc_pkg::SBSC_ST_SLEEP;
				else if (begin_rd || begin_wr)
					nxt_state = sbsc_pkg::SBSC_ST_BURST;
			end
			sbsc_pkg::SBSC_ST_BURST:
			begin
				if (sleep_sync_ff)
					nxt_state = sbsc_pkg::SBSC_ST_SLEEP;
				else if ((proc_start || ctrl_start) && !sel)
					nxt_state = sbsc_pkg::SBSC_ST_IDLE;
			end
			sbsc_pkg::SBSC_ST_SLEEP:
			begin
				if (!sleep_sync_ff)
					nxt_state = sbsc_pkg::SBSC_ST_IDLE;
			end
			default:
				nxt_state = sbsc_pkg::SBSC_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			state_ff <= sbsc_pkg::SBSC_ST_IDLE;
		else if (ce_i)
			state_ff <= nxt_state;
	end

	// Burst counter: start address latched, step counts from zero
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			hi_ff    <= '0;
			start_ff <= sbsc_pkg::CNT_ZERO;
			step_ff  <= sbsc_pkg::CNT_ZERO;
		end
		else if (ce_i)
		begin
			if (begin_rd || begin_wr)
			begin
				hi_ff    <= addr_i[sbsc_pkg::ADDR_W-1:sbsc_pkg::CNT_W];
				start_ff <= addr_i[sbsc_pkg::CNT_W-1:0];
				step_ff  <= sbsc_pkg::CNT_ZERO;
			end
			else
				step_ff <= nxt_step;
		end
	end

	// write or deselect drops read drive
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			read_valid_ff <= 1'b0;
		else if (ce_i)
			read_valid_ff <= rd_en;
	end

	assign data_oe_o   = read_valid_ff && !output_enable_n_i && (state_ff != sbsc_pkg::SBSC_ST_SLEEP);
	assign parity_oe_o = data_oe_o;
endmodule : sbsc_top
`default_nettype wire
